//--- core/pao_adc_port.sv
// Digital output side of a 12-bit pipelined sampling converter.
// Assumes quantised samples arrive on mclk; the drive-enable pin is asynchronous.
//
// Functional notes
// - Results are twos complement: +FS 7FF, zero 000, -FS 800.
// - Offset binary is the twos complement word with its top bit inverted.
// - Out-of-range flag is 1 above +FS or below -FS, else 0.
// - While out of range the word clamps to +FS or -FS code.
// - Drive enable low floats all data outputs; high drives them.
// - Unless the capture side stalls, each sample reaches the outputs three clock cycles after it is taken.
// - Internal timing uses both rising and falling clock edges.
// - Each sample is taken on the rising clock edge.
`include "pao_cfg.svh"

module pao_adc_port
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Quantised samples from the front end
  input wire logic signed [`PAO_RAW_W-1:0] samp_code,
  output logic samp_taken,
  // Output pins
  input wire logic output_drive_enable,
  output logic [`PAO_CODE_W-1:0] data_o,
  output logic [`PAO_CODE_W-1:0] data_oe,
  output logic data_msb_inv_o,
  output logic data_msb_inv_oe,
  output logic out_of_range_flag,
  output logic out_of_range_oe,
  // Capture handshake
  output logic word_valid,
  input wire logic capture_ready
);

  function automatic pao_pkg::pao_word_t pao_clamp(input logic signed [`PAO_RAW_W-1:0] raw);
    pao_pkg::pao_word_t w;
    w.code = raw[`PAO_CODE_W-1:0];
    w.oor = 1'b0;
    if (raw > $signed(`PAO_RAW_POS_FS))
    begin
      w.code = `PAO_POS_FS;
      w.oor = 1'b1;
    end
    else if (raw < $signed(`PAO_RAW_NEG_FS))
    begin
      w.code = `PAO_NEG_FS;
      w.oor = 1'b1;
    end
    return w;
  endfunction : pao_clamp

  logic adv;
  logic oe_meta_r;
  logic oe_sync_r;
  logic s0_v_r;
  logic signed [`PAO_RAW_W-1:0] s0_raw_r;
  logic s1_v_r;
  logic signed [`PAO_RAW_W-1:0] s1_raw_r;
  logic s2_v_r;
  pao_pkg::pao_word_t s2_r;
  logic s3_v_r;
  pao_pkg::pao_word_t s3_r;
  pao_pkg::pao_word_t head;

  // A capture-side stall freezes the whole pipeline once the output buffer is full; no sample is taken then.
  assign samp_taken = adv;

  // Sample on the rising edge.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s0_v_r <= 1'b0;
      s0_raw_r <= '0;
    end
    else if (adv)
    begin
      s0_v_r <= 1'b1;
      s0_raw_r <= samp_code;
    end
  end

  // The half-cycle stage works off the falling edge, between the rising-edge stages.
  always_ff @(negedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_v_r <= 1'b0;
      s1_raw_r <= '0;
    end
    else
    begin
      s1_v_r <= s0_v_r;
      s1_raw_r <= s0_raw_r;
    end
  end

  // Clamp and flag out-of-range inputs.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s2_v_r <= 1'b0;
      s2_r <= '0;
    end
    else if (adv)
    begin
      s2_v_r <= s1_v_r;
      s2_r <= pao_clamp(s1_raw_r);
    end
  end

  // Last pipeline stage so the buffer head shows the word three cycles on.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s3_v_r <= 1'b0;
      s3_r <= '0;
    end
    else if (adv)
    begin
      s3_v_r <= s2_v_r;
      s3_r <= s2_r;
    end
  end

  pao_out_buf u_buf
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(s3_v_r),
    .in_ready(adv),
    .in_word(s3_r),
    .out_valid(word_valid),
    .out_ready(capture_ready),
    .out_word(head)
  );

  // The enable pin is asynchronous, so it is synchronised before use.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_meta_r <= 1'b0;
      oe_sync_r <= 1'b0;
    end
    else
    begin
      oe_meta_r <= output_drive_enable;
      oe_sync_r <= oe_meta_r;
    end
  end

  // Floated pins output zero so no stale code leaks while the enable is off.
  assign data_oe = {`PAO_CODE_W{oe_sync_r}};
  assign data_o = oe_sync_r ? head.code : '0;
  assign out_of_range_oe = oe_sync_r;
  assign out_of_range_flag = oe_sync_r & head.oor;
  assign data_msb_inv_oe = oe_sync_r;
  assign data_msb_inv_o = oe_sync_r & ~head.code[`PAO_CODE_W-1];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_clamp_pos_fs: assert property (adv && s1_v_r && s1_raw_r > $signed(`PAO_RAW_POS_FS)
    |=> s2_r.code == `PAO_POS_FS && s2_r.oor)
    else $error("Over-range did not clamp to positive full scale.");

  a_clamp_neg_fs: assert property (adv && s1_v_r && s1_raw_r < $signed(`PAO_RAW_NEG_FS)
    |=> s2_r.code == `PAO_NEG_FS && s2_r.oor)
    else $error("Under-range did not clamp to negative full scale.");

  a_in_range_pass: assert property (adv && s1_v_r && s1_raw_r <= $signed(`PAO_RAW_POS_FS)
    && s1_raw_r >= $signed(`PAO_RAW_NEG_FS)
    |=> s2_r.code == $past(s1_raw_r[`PAO_CODE_W-1:0]) && !s2_r.oor)
    else $error("In-range sample was altered or flagged.");

  a_offset_msb: assert property (oe_sync_r |-> data_msb_inv_o != data_o[`PAO_CODE_W-1])
    else $error("Inverted top bit does not match the data word.");

  a_float_off: assert property (!oe_sync_r |-> data_oe == '0 && !out_of_range_oe && !data_msb_inv_oe)
    else $error("Outputs driven while drive enable is low.");

  a_drive_on_delay: assert property ($rose(output_drive_enable) ##1 output_drive_enable
    |=> data_oe == {`PAO_CODE_W{1'b1}} && out_of_range_oe)
    else $error("Outputs not driven two cycles after enable rose.");

  a_pipe_latency: assert property (samp_taken [*3]
    |=> s3_r == pao_clamp($past(samp_code, `PAO_LATENCY)))
    else $error("Sample did not reach the last stage in three cycles.");

  a_half_stage: assert property (s0_v_r |-> s1_v_r && s1_raw_r == s0_raw_r)
    else $error("Falling-edge stage lost the sampled value.");

  a_stall_hold: assert property (!adv |=> $stable(s3_r) && $stable(s2_r))
    else $error("Pipeline moved while the buffer was full.");

  c_pos_clamp: cover property (s2_r.oor && s2_r.code == `PAO_POS_FS);
  c_neg_clamp: cover property (s2_r.oor && s2_r.code == `PAO_NEG_FS);
  c_buf_stall: cover property (!adv ##1 adv);
  c_oe_toggle: cover property (oe_sync_r ##1 !oe_sync_r ##[1:20] oe_sync_r);

endmodule : pao_adc_port

//--- core/pao_out_buf.sv
// Two-entry output buffer between the conversion pipeline and the capture logic.
// Assumes one clock, an active-low asynchronous reset and a same-clock receiver.
`include "pao_cfg.svh"

module pao_out_buf
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire pao_pkg::pao_word_t in_word,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output pao_pkg::pao_word_t out_word
);

  pao_pkg::pao_word_t head_r;
  pao_pkg::pao_word_t tail_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // The head is always a register so the pins never see a read mux.
  assign in_ready = (cnt_r != `PAO_CNT_FULL);
  assign out_valid = (cnt_r != `PAO_CNT_EMPTY);
  assign out_word = head_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= `PAO_CNT_EMPTY;
    end
    else if (push && !pop)
    begin
      cnt_r <= cnt_r + `PAO_CNT_ONE;
    end
    else if (pop && !push)
    begin
      cnt_r <= cnt_r - `PAO_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_r <= '0;
      tail_r <= '0;
    end
    else
    begin
      case (cnt_r)
        `PAO_CNT_EMPTY:
        begin
          if (push)
            head_r <= in_word;
        end
        `PAO_CNT_ONE:
        begin
          if (push && pop)
            head_r <= in_word;
          else if (push)
            tail_r <= in_word;
        end
        `PAO_CNT_FULL:
        begin
          if (pop)
            head_r <= tail_r;
        end
        default:
        begin
          head_r <= head_r;
        end
      endcase
    end
  end

endmodule : pao_out_buf

//--- pkg/pao_cfg.svh
// Constants of the converter output port: widths, full-scale codes, latency.
// Assumes it is included by bare name from the package and the design files.
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH

`define PAO_CODE_W 12
`define PAO_RAW_W 14
`define PAO_POS_FS 12'h7FF
`define PAO_NEG_FS 12'h800
`define PAO_RAW_POS_FS 14'h07FF
`define PAO_RAW_NEG_FS 14'h3800
`define PAO_LATENCY 3
`define PAO_CNT_EMPTY 2'h0
`define PAO_CNT_ONE 2'h1
`define PAO_CNT_FULL 2'h2

`endif

//--- pkg/pao_pkg.sv
// Types shared by the converter output port and its output buffer.
// Assumes pao_cfg.svh is on the include path.
`include "pao_cfg.svh"

package pao_pkg;

  // One converted word as it leaves the pipeline.
  typedef struct packed
  {
    logic oor;
    logic [`PAO_CODE_W-1:0] code;
  } pao_word_t;

endpackage : pao_pkg

//--- tb/pao_cap.sv
// Capture logic model that latches each word leaving the converter port.
// Assumes the bench makes mclk and decides when this side stalls.
`include "pao_cfg.svh"

module pao_cap
(
  // Clock and control
  input wire logic mclk,
  input wire logic stall,
  // Pins from the converter
  input wire logic word_valid,
  input wire logic [`PAO_CODE_W-1:0] data_o,
  input wire logic out_of_range_flag,
  // Capture side
  output logic capture_ready,
  output pao_pkg::pao_word_t cap_word
);
  timeunit 1ns;
  timeprecision 1ns;

  assign capture_ready = !stall;

  // Word and flag share one edge, so a captured pair never mixes two samples.
  always_ff @(posedge mclk)
  begin
    if (word_valid && capture_ready)
      cap_word <= {out_of_range_flag, data_o};
  end
endmodule : pao_cap

//--- tb/tb.sv
// Self-checking bench for the converter output port.
// Assumes pao_cap stands in for the capture logic on the far side.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 0;
  logic rst_n = 0;
  logic en = 0;
  logic stall = 0;
  logic signed [13:0] samp = 14'sh0000;
  logic taken, valid, ready, inv, oor, inv_oe, oor_oe;
  logic [11:0] dout, doe;
  pao_pkg::pao_word_t cw;
  int fails = 0;
  int check_count = 0;

  pao_adc_port dut (.mclk(mclk), .rst_n(rst_n), .samp_code(samp), .samp_taken(taken),
    .output_drive_enable(en), .data_o(dout), .data_oe(doe), .data_msb_inv_o(inv),
    .data_msb_inv_oe(inv_oe), .out_of_range_flag(oor), .out_of_range_oe(oor_oe),
    .word_valid(valid), .capture_ready(ready));
  pao_cap cap (.mclk(mclk), .stall(stall), .word_valid(valid), .data_o(dout),
    .out_of_range_flag(oor), .capture_ready(ready), .cap_word(cw));

  // Even halves keep the duty cycle at 50% and the rate at 10 MHz.
  initial forever #50 mclk = ~mclk;

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Drive goes on during reset, ahead of the first sample, and every wait exceeds 50 ns.
  task automatic reset_test;
    step(3);
    chk({oor_oe, doe}, 13'h0000);
    chk({12'h000, valid}, 13'h0000);
    en = 1;
    step(1);
    rst_n = 1;
    step(1);
  endtask : reset_test

  // The two-flop delay on the pin keeps the pins floating just after reset.
  task automatic enable_test;
    chk({oor_oe, doe}, 13'h0000);
    step(3);
    chk({oor_oe, doe}, 13'h1FFF);
    chk({inv_oe, 12'h000}, 13'h1000);
  endtask : enable_test

  task automatic latency_test;
    samp = 14'sh0123;
    step(5);
    samp = 14'sh0456;
    step(3);
    chk({1'b0, dout}, 13'h0123);
    step(1);
    chk({1'b0, dout}, 13'h0456);
  endtask : latency_test

  task automatic format_test;
    logic signed [13:0] v[6] = '{14'sh07FF, 14'sh0000, 14'sh3800, 14'sh0800, 14'sh37FF, 14'sh0005};
    logic [12:0] e[6] = '{13'h07FF, 13'h0000, 13'h0800, 13'h17FF, 13'h1800, 13'h0005};
    for (int i = 0; i < 6; i++)
    begin
      samp = v[i];
      step(5);
      chk(cw, e[i]);
      chk({oor, dout}, e[i]);
      chk({12'h000, inv}, {12'h000, ~e[i][11]});
    end
  endtask : format_test

  // A long stall must freeze sampling rather than lose the head word.
  task automatic stall_test;
    samp = 14'sh0001;
    step(2);
    samp = 14'sh0002;
    step(3);
    stall = 1;
    step(6);
    chk({12'h000, taken}, 13'h0000);
    chk({valid, dout}, 13'h1001);
    stall = 0;
    step(1);
    chk({12'h000, taken}, 13'h0001);
    chk({1'b0, dout}, 13'h0002);
    step(1);
    chk(cw, 13'h0002);
  endtask : stall_test

  task automatic disable_test;
    en = 0;
    step(3);
    chk({oor_oe, doe}, 13'h0000);
    chk({oor, dout}, 13'h0000);
    chk({11'h000, inv_oe, inv}, 13'h0000);
    en = 1;
    step(3);
    chk({oor_oe, doe}, 13'h1FFF);
    chk({oor, dout}, 13'h0002);
  endtask : disable_test

  initial
  begin
    reset_test();
    enable_test();
    latency_test();
    format_test();
    stall_test();
    disable_test();
    end_sim();
  end

  // The whole run needs under a hundred cycles; a thousand means a hang.
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
endmodule : tb
